// ---- rtl/ntbbst_pkg.sv ----
// constants, types and helpers shared by the window setup register bank
// What this block does
// - translated base field 31:4 remaps window one
// - fields survive fundamental and hot resets
// - setup bit 0 selects memory or I/O
// - setup bits 2:1 pick 32 or 64-bit decode
// - decode type reads zero for I/O space
// - setup bit 3 reports prefetchable
// - size field is log2 of bytes, zero decodes as 16 bytes
// - base field bit 0 is address bit 4
// - size zero makes every base bit writable
// - bits below size read zero, above writable
// - size one to three disables the whole base field
// - narrow decode ignores size above 32
// - wide window zero takes upper half from here
// - enable bit 31 clear disables window, reads zero
package ntbbst_pkg;

  localparam int unsigned ADDR_W = 12;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned STRB_W = 4;

  localparam logic [11:0] OFF_ZERO_TBASE   = 12'h084;
  localparam logic [11:0] OFF_ONE_TBASE    = 12'h088;
  localparam logic [11:0] OFF_TWO_SETUP    = 12'h08c;
  localparam logic [11:0] OFF_TWO_BASE_LO  = 12'h0a0;
  localparam logic [11:0] OFF_TWO_BASE_HI  = 12'h0a4;
  localparam logic [11:0] OFF_ZERO_MODE    = 12'h0a8;

  localparam int unsigned SPACE_BIT  = 0;
  localparam int unsigned TYPE_LSB   = 1;
  localparam int unsigned TYPE_MSB   = 2;
  localparam int unsigned PREFETCH_SELECT_BIT   = 3;
  localparam int unsigned SIZE_LSB   = 4;
  localparam int unsigned SIZE_MSB   = 9;
  localparam int unsigned EN_BIT     = 31;
  localparam int unsigned FIELD_LSB  = 4;

  localparam logic [31:0] SETUP_RESET    = 32'h0000_0000;
  localparam logic [31:0] TBASE_RESET    = 32'h0000_0000;
  localparam logic [31:0] BASE_RESET     = 32'h0000_0000;
  localparam logic [31:0] MODE_RESET     = 32'h0000_0000;
  localparam logic [31:0] SETUP_WR_MASK  = 32'h8000_03ff;
  localparam logic [31:0] MODE_WR_MASK   = 32'h0000_0007;
  localparam logic [31:0] FIELD_MASK     = 32'hffff_fff0;

  localparam logic [5:0] SIZE_MIN_VALID  = 6'h04;
  localparam logic [5:0] SIZE_NARROW_MAX = 6'h20;
  localparam int unsigned NARROW_BITS    = 32;
  localparam int unsigned FULL_BITS      = 64;

  typedef enum logic [1:0] {
    DECODE_LOW_FOUR_GIG = 2'b00,
    DECODE_RSVD_ONE     = 2'b01,
    DECODE_FULL_WIDTH   = 2'b10,
    DECODE_RSVD_THREE   = 2'b11
  } ntbbst_decode_type;

  // byte-lane merge of a write into a stored word
  function automatic logic [31:0] merge_bytes(
    input logic [31:0] old_val,
    input logic [31:0] new_val,
    input logic [3:0]  strb
  );
    logic [31:0] res;
    res = old_val;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[i*8 +: 8] = new_val[i*8 +: 8];
      end
    end
    return res;
  endfunction

  // reserved decode codes fall back to narrow decoding
  function automatic logic is_wide(
    input logic       space_io,
    input logic [1:0] decode
  );
    return !space_io && (decode == DECODE_FULL_WIDTH);
  endfunction

endpackage

// ---- rtl/ntbbst_reg_if.sv ----
// register access carrier between the bus slave and the register bank
`timescale 1ns/1ps
`default_nettype none
interface ntbbst_reg_if;
  import ntbbst_pkg::*;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] wdata;
  logic [STRB_W-1:0] strb;
  logic              wr;
  logic [DATA_W-1:0] rd_data;
  logic              hit;

  modport slave (
    output addr,
    output wdata,
    output strb,
    output wr,
    input  rd_data,
    input  hit
  );
  modport regs (
    input  addr,
    input  wdata,
    input  strb,
    input  wr,
    output rd_data,
    output hit
  );
endinterface
`default_nettype wire

// ---- rtl/ntbbst_base_mask.sv ----
// writable-bit mask of the window base address from the current setup
`timescale 1ns/1ps
`default_nettype none
module ntbbst_base_mask (
  input  wire logic [5:0]  size,
  input  wire logic        wide,
  input  wire logic        enable,
  output logic      [63:0] mask
);
  import ntbbst_pkg::*;

  logic [5:0] eff_size;

  always_comb begin
    // narrow decode clamps the size, upper half is never decoded
    if (!wide && (size > SIZE_NARROW_MAX)) begin
      eff_size = SIZE_NARROW_MAX;
    end else begin
      eff_size = size;
    end
    mask = 64'h0;
    for (int i = FIELD_LSB; i < FULL_BITS; i++) begin
      if (enable && (wide || i < NARROW_BITS)) begin
        if (eff_size == 6'h00) begin
          mask[i] = 1'b1;
        end else if (eff_size >= SIZE_MIN_VALID) begin
          mask[i] = (i >= int'(eff_size));
        end
      end
    end
  end
endmodule
`default_nettype wire

// ---- rtl/ntbbst_apb_slave.sv ----
// apb slave front end: zero-wait access, read data caught in setup
`timescale 1ns/1ps
`default_nettype none
module ntbbst_apb_slave
  import ntbbst_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              rst,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [DATA_W-1:0] pwdata,
  input  wire logic [STRB_W-1:0] pstrb,
  output logic                   pready,
  output logic      [DATA_W-1:0] prdata,
  output logic                   pslverr,
  ntbbst_reg_if.slave            bus
);
  logic [DATA_W-1:0] rdata_q;
  logic [DATA_W-1:0] rdata_d;
  logic              err_q;
  logic              err_d;
  logic              setup;

  assign setup     = psel && !penable;
  assign bus.addr  = paddr;
  assign bus.wdata = pwdata;
  assign bus.strb  = pstrb;
  // the write lands on the completing edge, same cycle as pready
  assign bus.wr    = psel && penable && pwrite && bus.hit;
  assign pready    = psel && penable;
  assign pslverr   = psel && penable && err_q;
  assign prdata    = rdata_q;

  always_comb begin
    rdata_d = rdata_q;
    err_d   = err_q;
    if (setup) begin
      rdata_d = (pwrite || !bus.hit) ? 32'h0000_0000 : bus.rd_data;
      err_d   = !bus.hit;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      rdata_q <= 32'h0000_0000;
      err_q   <= 1'b0;
    end else begin
      rdata_q <= rdata_d;
      err_q   <= err_d;
    end
  end
endmodule
`default_nettype wire

// ---- rtl/ntbbst_window_regs.sv ----
// window setup and translated base register bank, apb reachable
`timescale 1ns/1ps
`default_nettype none
module ntbbst_window_regs
  import ntbbst_pkg::*;
(
  input  wire logic                           SYS_CLK,
  input  wire logic                           RST,
  input  wire logic                           PWRUP_RST,
  input  wire logic                           PSEL,
  input  wire logic                           PENABLE,
  input  wire logic                           PWRITE,
  input  wire logic [ntbbst_pkg::ADDR_W-1:0]  PADDR,
  input  wire logic [ntbbst_pkg::DATA_W-1:0]  PWDATA,
  input  wire logic [ntbbst_pkg::STRB_W-1:0]  PSTRB,
  output logic                                PREADY,
  output logic      [ntbbst_pkg::DATA_W-1:0]  PRDATA,
  output logic                                PSLVERR,
  output logic                                WIN_ENABLE,
  output logic                                WIN_IO,
  output logic                                WIN_WIDE,
  output logic                                WIN_PREFETCH,
  output logic      [63:0]                    WIN_BASE,
  output logic      [63:0]                    WIN_ADDR_MASK,
  output logic                                ZERO_WIDE,
  output logic      [63:0]                    ZERO_TBASE,
  output logic                                ONE_TBASE_VALID,
  output logic      [63:0]                    ONE_TBASE
);
  import ntbbst_pkg::*;

  ntbbst_reg_if bus ();

  // sticky configuration, cleared only at power-up
  logic [31:0] setup_q;
  logic [31:0] setup_d;
  logic [31:0] zero_tb_q;
  logic [31:0] zero_tb_d;
  logic [31:0] one_tb_q;
  logic [31:0] one_tb_d;
  logic [31:0] zero_mode_q;
  logic [31:0] zero_mode_d;
  logic [63:0] base_q;
  logic [63:0] base_d;

  // registered outputs
  logic        en_q;
  logic        io_q;
  logic        wide_q;
  logic        prefetch_select_q;
  logic [63:0] win_base_q;
  logic [63:0] win_mask_q;
  logic        zero_wide_q;
  logic [63:0] zero_tb_out_q;
  logic [63:0] one_tb_out_q;
  logic        en_d;
  logic        io_d;
  logic        wide_d;
  logic        prefetch_select_d;
  logic [63:0] win_base_d;
  logic [63:0] win_mask_d;
  logic        zero_wide_d;
  logic [63:0] zero_tb_out_d;
  logic [63:0] one_tb_out_d;

  logic        space_io;
  logic [1:0]  decode_rd;
  logic        win_en;
  logic        wide_two;
  logic        wide_zero;
  logic [5:0]  size;
  logic [63:0] base_mask;
  logic [63:0] base_vis;
  logic [31:0] setup_rd;
  logic [31:0] one_tb_mask;
  logic [31:0] rd_data;
  logic        hit;

  ntbbst_apb_slave u_apb (
    .clk     (SYS_CLK),
    .rst     (RST),
    .psel    (PSEL),
    .penable (PENABLE),
    .pwrite  (PWRITE),
    .paddr   (PADDR),
    .pwdata  (PWDATA),
    .pstrb   (PSTRB),
    .pready  (PREADY),
    .prdata  (PRDATA),
    .pslverr (PSLVERR),
    .bus     (bus)
  );

  ntbbst_base_mask u_mask (
    .size   (size),
    .wide   (wide_two),
    .enable (win_en),
    .mask   (base_mask)
  );

  assign space_io  = setup_q[SPACE_BIT];
  assign win_en    = setup_q[EN_BIT];
  assign size      = setup_q[SIZE_MSB:SIZE_LSB];
  assign wide_two  = is_wide(space_io, setup_q[TYPE_MSB:TYPE_LSB]);
  assign wide_zero = is_wide(zero_mode_q[SPACE_BIT],
                             zero_mode_q[TYPE_MSB:TYPE_LSB]);
  // stale bits are hidden at once, even before the store is trimmed
  assign base_vis  = base_q & base_mask;
  assign decode_rd = space_io ? 2'b00 : setup_q[TYPE_MSB:TYPE_LSB];
  // low nibble of the window one translated base is only live in wide mode
  assign one_tb_mask = wide_zero ? 32'hffff_ffff : FIELD_MASK;

  always_comb begin
    setup_rd                      = 32'h0000_0000;
    setup_rd[SPACE_BIT]           = space_io;
    setup_rd[TYPE_MSB:TYPE_LSB]   = decode_rd;
    setup_rd[PREFETCH_SELECT_BIT]            = setup_q[PREFETCH_SELECT_BIT];
    setup_rd[SIZE_MSB:SIZE_LSB]   = size;
    setup_rd[EN_BIT]              = win_en;
  end

  always_comb begin
    rd_data = 32'h0000_0000;
    hit     = 1'b1;
    unique case (bus.addr)
      OFF_ZERO_TBASE:  rd_data = zero_tb_q & FIELD_MASK;
      OFF_ONE_TBASE:   rd_data = one_tb_q & one_tb_mask;
      OFF_TWO_SETUP:   rd_data = setup_rd;
      OFF_ZERO_MODE:   rd_data = zero_mode_q & MODE_WR_MASK;
      OFF_TWO_BASE_LO: begin
        // disabled window reads back as all zero
        if (win_en) begin
          rd_data = {base_vis[31:FIELD_LSB], setup_q[PREFETCH_SELECT_BIT],
                     decode_rd, space_io};
        end
      end
      OFF_TWO_BASE_HI: rd_data = wide_two ? base_vis[63:32] : 32'h0;
      default:         hit = 1'b0;
    endcase
  end

  assign bus.rd_data = rd_data;
  assign bus.hit     = hit;

  always_comb begin
    setup_d     = setup_q;
    zero_tb_d   = zero_tb_q;
    one_tb_d    = one_tb_q;
    zero_mode_d = zero_mode_q;
    // trim bits that the current setup no longer lets software hold
    base_d      = base_q & base_mask;
    if (bus.wr) begin
      unique case (bus.addr)
        OFF_TWO_SETUP: begin
          setup_d = merge_bytes(setup_q, bus.wdata, bus.strb)
                    & SETUP_WR_MASK;
        end
        OFF_ZERO_TBASE: begin
          zero_tb_d = merge_bytes(zero_tb_q, bus.wdata, bus.strb)
                      & FIELD_MASK;
        end
        OFF_ONE_TBASE: begin
          one_tb_d = merge_bytes(one_tb_q, bus.wdata, bus.strb)
                     & one_tb_mask;
        end
        OFF_ZERO_MODE: begin
          zero_mode_d = merge_bytes(zero_mode_q, bus.wdata, bus.strb)
                        & MODE_WR_MASK;
        end
        OFF_TWO_BASE_LO: begin
          base_d[31:0] = merge_bytes(base_q[31:0], bus.wdata, bus.strb)
                         & base_mask[31:0];
        end
        OFF_TWO_BASE_HI: begin
          base_d[63:32] = merge_bytes(base_q[63:32], bus.wdata, bus.strb)
                          & base_mask[63:32];
        end
        default: begin
        end
      endcase
    end
  end

  // RST is the fundamental/hot reset and leaves these untouched
  always_ff @(posedge SYS_CLK) begin
    if (PWRUP_RST) begin
      setup_q     <= SETUP_RESET;
      zero_tb_q   <= TBASE_RESET;
      one_tb_q    <= TBASE_RESET;
      zero_mode_q <= MODE_RESET;
      base_q      <= {BASE_RESET, BASE_RESET};
    end else begin
      setup_q     <= setup_d;
      zero_tb_q   <= zero_tb_d;
      one_tb_q    <= one_tb_d;
      zero_mode_q <= zero_mode_d;
      base_q      <= base_d;
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (PWRUP_RST) begin
      en_q          <= 1'b0;
      io_q          <= 1'b0;
      wide_q        <= 1'b0;
      prefetch_select_q        <= 1'b0;
      win_base_q    <= 64'h0;
      win_mask_q    <= 64'h0;
      zero_wide_q   <= 1'b0;
      zero_tb_out_q <= 64'h0;
      one_tb_out_q  <= 64'h0;
    end else begin
      en_q          <= en_d;
      io_q          <= io_d;
      wide_q        <= wide_d;
      prefetch_select_q        <= prefetch_select_d;
      win_base_q    <= win_base_d;
      win_mask_q    <= win_mask_d;
      zero_wide_q   <= zero_wide_d;
      zero_tb_out_q <= zero_tb_out_d;
      one_tb_out_q  <= one_tb_out_d;
    end
  end

  always_comb begin
    en_d          = win_en;
    io_d          = space_io;
    wide_d        = wide_two;
    prefetch_select_d        = setup_q[PREFETCH_SELECT_BIT];
    win_base_d    = base_vis;
    win_mask_d    = ~base_mask & {{60{1'b1}}, 4'h0} & {64{win_en}};
    zero_wide_d   = wide_zero;
    zero_tb_out_d = {wide_zero ? one_tb_q : 32'h0,
                     zero_tb_q & FIELD_MASK};
    one_tb_out_d  = {32'h0, one_tb_q & FIELD_MASK};
  end

  assign WIN_ENABLE      = en_q;
  assign WIN_IO          = io_q;
  assign WIN_WIDE        = wide_q;
  assign WIN_PREFETCH    = prefetch_select_q;
  assign WIN_BASE        = win_base_q;
  assign WIN_ADDR_MASK   = win_mask_q;
  assign ZERO_WIDE       = zero_wide_q;
  assign ZERO_TBASE      = zero_tb_out_q;
  // window one is its own window only while window zero is narrow
  assign ONE_TBASE_VALID = !zero_wide_q;
  assign ONE_TBASE       = one_tb_out_q;
endmodule
`default_nettype wire

// ---- testbench/ntbbst_window_regs_sva.sv ----
// assertions on the ports of the window setup register bank
`timescale 1ns/1ps
`default_nettype none
module ntbbst_window_regs_chk
  import ntbbst_pkg::*;
(
  input wire logic                          SYS_CLK,
  input wire logic                          RST,
  input wire logic                          PWRUP_RST,
  input wire logic                          PSEL,
  input wire logic                          PENABLE,
  input wire logic                          PWRITE,
  input wire logic [ntbbst_pkg::ADDR_W-1:0] PADDR,
  input wire logic [ntbbst_pkg::DATA_W-1:0] PWDATA,
  input wire logic [ntbbst_pkg::STRB_W-1:0] PSTRB,
  input wire logic                          PREADY,
  input wire logic                          WIN_ENABLE,
  input wire logic                          WIN_IO,
  input wire logic                          WIN_WIDE,
  input wire logic [63:0]                   WIN_BASE,
  input wire logic [63:0]                   WIN_ADDR_MASK,
  input wire logic                          ZERO_WIDE,
  input wire logic                          ONE_TBASE_VALID,
  input wire logic [63:0]                   ONE_TBASE
);
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (PWRUP_RST);
  sequence tbase_wr_s;
    PSEL && PENABLE && PWRITE && PADDR == OFF_ONE_TBASE
      && PSTRB == 4'hf && !ZERO_WIDE;
  endsequence
  sequence tbase_seen_s;
    ##2 ONE_TBASE[31:0] == {$past(PWDATA[31:4], 2), 4'h0};
  endsequence
  ready_now_a: assert property (PREADY == (PSEL && PENABLE))
    else $error("ready does not follow access phase");
  tbase_write_a: assert property (tbase_wr_s |-> tbase_seen_s)
    else $error("translated base not taken from write");
  tbase_zero_a: assert property (
    ONE_TBASE[3:0] == 4'h0 && ONE_TBASE[63:32] == 32'h0)
    else $error("translated base holds bits outside 31:4");
  io_narrow_a: assert property (WIN_IO |-> !WIN_WIDE)
    else $error("io window decodes wide");
  base_low_a: assert property (WIN_BASE[3:0] == 4'h0)
    else $error("base holds bits below address bit 4");
  base_mask_a: assert property ((WIN_BASE & WIN_ADDR_MASK) == 64'h0)
    else $error("base bit set inside window");
  narrow_hi_a: assert property (
    WIN_ENABLE && !WIN_WIDE |-> WIN_BASE[63:32] == 32'h0)
    else $error("narrow window has upper base bits");
  off_zero_a: assert property (
    !WIN_ENABLE |-> WIN_ADDR_MASK == 64'h0 && WIN_BASE == 64'h0)
    else $error("disabled window not zero");
  upper_use_a: assert property (ONE_TBASE_VALID == !ZERO_WIDE)
    else $error("upper half use not tied to wide mode");
  hot_keep_a: assert property (
    RST |=> $stable(WIN_BASE) && $stable(ONE_TBASE))
    else $error("config changed over hot reset");
endmodule
bind ntbbst_window_regs ntbbst_window_regs_chk u_chk (.*);
`default_nettype wire

// ---- testbench/ntbbst_window_regs_tb.sv ----
// self-checking bench of the window setup register bank
`timescale 1ns/1ps
`default_nettype none
module ntbbst_window_regs_tb;
  import ntbbst_pkg::*;
  logic        clk;
  logic        rst = 1'b1;
  logic        pwrup = 1'b1;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0;
  logic [3:0]  pstrb = 4'hf;
  logic        pready, pslverr, en, io, wide, prefetch_select, zwide, ovalid, err;
  logic [31:0] prdata, rd;
  logic [63:0] base, amask, ztb, otb;
  int          mismatches = 0;
  int          n_compared = 0;

  ntbbst_window_regs DUT (
    .SYS_CLK(clk), .RST(rst), .PWRUP_RST(pwrup), .PSEL(psel),
    .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr),
    .PWDATA(pwdata), .PSTRB(pstrb), .PREADY(pready),
    .PRDATA(prdata), .PSLVERR(pslverr), .WIN_ENABLE(en),
    .WIN_IO(io), .WIN_WIDE(wide), .WIN_PREFETCH(prefetch_select),
    .WIN_BASE(base), .WIN_ADDR_MASK(amask), .ZERO_WIDE(zwide),
    .ZERO_TBASE(ztb), .ONE_TBASE_VALID(ovalid), .ONE_TBASE(otb)
  );

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  task automatic end_sim();
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic chk(input logic [63:0] s, input logic [63:0] e);
    n_compared++;
    if (s !== e) begin
      mismatches++;
      $display("BAD %0t seen %h want %h", $time, s, e);
    end
  endtask

  // one idle cycle after each transfer keeps psel from two writes at once
  task automatic acc(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask

  task automatic rchk(input logic [11:0] a, input logic [31:0] e);
    acc(1'b0, a, 32'h0);
    chk({32'h0, rd}, {32'h0, e});
  endtask

  // setup write, readback, then full base write and its readback
  task automatic win(input logic [31:0] s, input logic [31:0] es,
                     input logic [31:0] el);
    acc(1'b1, OFF_TWO_SETUP, s);
    rchk(OFF_TWO_SETUP, es);
    acc(1'b1, OFF_TWO_BASE_LO, 32'hffff_ffff);
    rchk(OFF_TWO_BASE_LO, el);
  endtask

  initial begin
    #100000;
    mismatches++;
    end_sim();
  end

  initial begin
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    pwrup <= 1'b0;
    @(posedge clk);
    rchk(OFF_TWO_SETUP, SETUP_RESET);
    rchk(OFF_ONE_TBASE, TBASE_RESET);
    acc(1'b1, OFF_ONE_TBASE, 32'hffff_ffff);
    rchk(OFF_ONE_TBASE, 32'hffff_fff0);
    chk(otb, 64'h0000_0000_ffff_fff0);
    chk(ovalid, 1'b1);
    // io, decode written, size 63 clipped to 32 so no low bits writable
    win(32'hffff_ffff, 32'h8000_03f9, 32'h0000_0009);
    chk({io, wide, prefetch_select, en}, 4'hb);
    win(32'h8000_0004, 32'h8000_0004, 32'hffff_fff4);
    acc(1'b1, OFF_TWO_BASE_HI, 32'hffff_ffff);
    rchk(OFF_TWO_BASE_HI, 32'hffff_ffff);
    chk(base, 64'hffff_ffff_ffff_fff0);
    chk(amask, 64'h0);
    win(32'h8000_00c4, 32'h8000_00c4, 32'hffff_f004);
    chk(amask, 64'h0ff0);
    chk(base, 64'hffff_ffff_ffff_f000);
    win(32'h8000_0024, 32'h8000_0024, 32'h0000_0004);
    rchk(OFF_TWO_BASE_HI, 32'h0);
    win(32'h8000_0280, 32'h8000_0280, 32'h0);
    rchk(OFF_TWO_BASE_HI, 32'h0);
    // memory windows kept at size 7 while the decode type steps through all four codes
    for (int c = 0; c < 4; c++) begin
      win(32'h8000_0070 | 32'(c << 1), 32'h8000_0070 | 32'(c << 1),
          32'hffff_ff80 | 32'(c << 1));
      chk(wide, c == 2);
    end
    win(32'h0000_00c4, 32'h0000_00c4, 32'h0);
    chk(en, 1'b0);
    chk(amask, 64'h0);
    chk(base, 64'h0);
    acc(1'b0, 12'h000, 32'h0);
    chk({err, rd}, {1'b1, 32'h0});
    acc(1'b1, OFF_ONE_TBASE, 32'h1234_5678);
    pstrb <= 4'h2;
    acc(1'b1, OFF_ONE_TBASE, 32'h0000_aa00);
    pstrb <= 4'hf;
    rst <= 1'b1;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rchk(OFF_ONE_TBASE, 32'h1234_aa70);
    rchk(OFF_TWO_SETUP, 32'h0000_00c4);
    acc(1'b1, OFF_ZERO_MODE, 32'h4);
    acc(1'b1, OFF_ZERO_TBASE, 32'h1234_5678);
    acc(1'b1, OFF_ONE_TBASE, 32'hffff_ffff);
    rchk(OFF_ONE_TBASE, 32'hffff_ffff);
    chk({zwide, ovalid}, 2'b10);
    chk(ztb, 64'hffff_ffff_1234_5670);
    end_sim();
  end
endmodule
`default_nettype wire
